// ---- dhie_pkg.sv ----
// Package: encodings, field positions and types for the instruction group
// Contract
// - Unsigned divide: quotient to low result, remainder to high result.
// - Unsigned divide never raises an arithmetic exception.
// - Zero divisor leaves undefined values in the result registers.
// - Hazard barrier is shift-left-logical with zero registers, amount 3.
// - Hazard barrier stalls issue until execution hazards clear, even in slots.
// - Hazard barrier does not clear instruction hazards.
// - Enable-interrupts writes old status to destination, then sets enable.
// - Selector bit 1 enables, 0 disables; system opcode, register field 12.
// - Status read and update by enable-interrupts is indivisible.
// - No system-coprocessor access raises coprocessor-unusable instead.
// - Earlier release raises reserved-instruction for enable-interrupts.
// - Interrupt-enable change needs a barrier, not a fixed delay.
// - Exception return picks error or exception address, clears level bit.
// - Return copies previous shadow set only under four conditions.
// - Exception return clears the load-linked flag.
// - Exception return has no delay slot.
// - Exception return clears all hazards from the target fetch onward.
// - Extract takes size bits from pos, right-justified, zero-extended.
// - Extract decodes width-minus-one at 15..11, position at 10..6.
// - Extract result is undefined when pos plus width-minus-one exceeds 31.
// - Result register reads stall until a multi-cycle divide completes.
`default_nettype none
package dhie_pkg;
    localparam logic [5:0] OP_SPECIAL   = 6'h00;
    localparam logic [5:0] OP_SPECIAL3  = 6'h1F;
    localparam logic [5:0] OP_SYSCOP    = 6'h10;
    localparam logic [5:0] FN_SLL       = 6'h00;
    localparam logic [5:0] FN_UDIV      = 6'h1B;
    localparam logic [5:0] FN_MFHI      = 6'h10;
    localparam logic [5:0] FN_MFLO      = 6'h12;
    localparam logic [5:0] FN_EXTRACT   = 6'h00;
    localparam logic [5:0] FN_EXCEPTION_RETURN      = 6'h18;
    localparam logic [4:0] RS_MISC      = 5'h0B;
    localparam logic [4:0] RS_CO        = 5'h10;
    localparam logic [4:0] RD_STATUS    = 5'h0C;
    localparam logic [4:0] SHAMT_BARR   = 5'h03;
    localparam int         SEL_BIT      = 5;
    localparam int         MSBD_HI      = 15;
    localparam int         MSBD_LO      = 11;
    localparam int         LSB_HI       = 10;
    localparam int         LSB_LO       = 6;
    localparam int         ST_IE        = 0;
    localparam int         ST_EXL       = 1;
    localparam int         ST_ERL       = 2;
    localparam int         ST_BEV       = 22;
    localparam int         DIV_CYCLES   = 32;
    localparam logic [31:0] STATUS_RST  = 32'h0040_0004;
    localparam logic [3:0]  SHADOW_RST  = 4'h0;
    localparam int          ARCH_REV_DEF = 2;

    typedef enum logic [2:0] {
        DHIE_EXC_NONE, DHIE_EXC_CPU, DHIE_EXC_RI
    } dhie_exc_t;

    typedef struct packed {
        logic [3:0] highest;
        logic [3:0] previous;
        logic [3:0] current;
    } dhie_shadow_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] instr;
        logic [31:0] rsVal;
        logic [31:0] rtVal;
    } dhie_issue_t;

    typedef struct packed {
        logic        we;
        logic [4:0]  addr;
        logic [31:0] data;
    } dhie_wb_t;
endpackage
`default_nettype wire

// ---- dhie_exec.sv ----
// Execution unit for divide, barrier, interrupt enable, return, extract
`default_nettype none
module dhie_exec
    import dhie_pkg::*;
#(
    parameter int ARCH_REV   = ARCH_REV_DEF,
    parameter int DIV_STEPS  = DIV_CYCLES
) (
    input  wire logic         clk,
    input  wire logic         reset,
    input  wire dhie_issue_t  issue,
    input  wire logic         cop0Usable,
    input  wire logic         compressedIsa,
    input  wire logic         hazardPending,
    input  wire logic [31:0]  exceptionReturnPc,
    input  wire logic [31:0]  errorReturnPc,
    output logic              issueStall,
    output var  dhie_wb_t     writeBack,
    output logic              excValid,
    output var  dhie_exc_t    excCause,
    output logic              redirectValid,
    output logic [31:0]       redirectPc,
    output logic              isaSelect,
    output logic              clearExecHazards,
    output logic              clearInstrHazards,
    output logic              squashNext,
    output logic [31:0]       statusWord,
    output logic              globalIrqEnable,
    output var  dhie_shadow_t shadowSetControl,
    output logic              loadLinkedFlag,
    input  wire logic         loadLinkedSet,
    input  wire logic         shadowWe,
    input  wire dhie_shadow_t shadowWdata,
    input  wire logic         statusWe,
    input  wire logic [31:0]  statusWdata,
    output logic [31:0]       resultHighReg,
    output logic [31:0]       resultLowReg,
    output logic              divBusy
);

    ////////////////////////////////////////////////////////////////////////
    // Decode
    logic [5:0]  opc;
    logic [5:0]  fnc;
    logic [4:0]  rsF;
    logic [4:0]  rtF;
    logic [4:0]  rdF;
    logic [4:0]  shF;
    logic        isDiv;
    logic        isBarrier;
    logic        isIrqInstr;
    logic        isEret;
    logic        isExtract;
    logic        isHiLoRead;
    logic        fire;

    assign opc = issue.instr[31:26];
    assign fnc = issue.instr[5:0];
    assign rsF = issue.instr[25:21];
    assign rtF = issue.instr[20:16];
    assign rdF = issue.instr[15:11];
    assign shF = issue.instr[10:6];

    assign isDiv      = issue.valid && opc == OP_SPECIAL && fnc == FN_UDIV;
    assign isBarrier  = issue.valid && opc == OP_SPECIAL && fnc == FN_SLL
                        && rsF == 5'h00 && rtF == 5'h00 && rdF == 5'h00
                        && shF == SHAMT_BARR;
    assign isIrqInstr = issue.valid && opc == OP_SYSCOP && rsF == RS_MISC
                        && rdF == RD_STATUS && shF == 5'h00
                        && issue.instr[4:0] == 5'h00;
    assign isEret     = issue.valid && opc == OP_SYSCOP && rsF == RS_CO
                        && issue.instr[20:6] == 15'h0000
                        && fnc == FN_EXCEPTION_RETURN;
    assign isExtract  = issue.valid && opc == OP_SPECIAL3
                        && fnc == FN_EXTRACT;
    assign isHiLoRead = issue.valid && opc == OP_SPECIAL
                        && (fnc == FN_MFHI || fnc == FN_MFLO);

    ////////////////////////////////////////////////////////////////////////
    // Stall: divider busy blocks result reads and a new divide
    logic divDone;
    assign issueStall = (divBusy && (isHiLoRead || isDiv))
                        || (isBarrier && hazardPending);
    assign fire = !issueStall;

    ////////////////////////////////////////////////////////////////////////
    // Iterative unsigned divider, one quotient bit per cycle
    logic [31:0] divisor_q;
    logic [31:0] quot_q;
    logic [32:0] rem_q;
    logic [5:0]  count_q;
    logic [32:0] trial;

    assign trial = {rem_q[31:0], quot_q[31]} - {1'b0, divisor_q};
    assign divDone = divBusy && count_q == 6'(DIV_STEPS - 1);

    // Operands zero-extended, so no sign logic and no trap path
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            divBusy   <= 1'b0;
            count_q   <= 6'h00;
            divisor_q <= 32'h0000_0000;
            quot_q    <= 32'h0000_0000;
            rem_q     <= 33'h0_0000_0000;
        end else if (isDiv && fire) begin
            divBusy   <= 1'b1;
            count_q   <= 6'h00;
            divisor_q <= issue.rtVal;
            quot_q    <= issue.rsVal;
            rem_q     <= 33'h0_0000_0000;
        end else if (divBusy) begin
            count_q <= count_q + 6'h01;
            if (!trial[32]) begin
                rem_q  <= trial;
                quot_q <= {quot_q[30:0], 1'b1};
            end else begin
                rem_q  <= {rem_q[31:0], quot_q[31]};
                quot_q <= {quot_q[30:0], 1'b0};
            end
            if (divDone) begin
                divBusy <= 1'b0;
            end
        end
    end

    // Zero divisor gives all-ones quotient; value is undefined anyway
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            resultHighReg <= 32'h0000_0000;
            resultLowReg  <= 32'h0000_0000;
        end else if (divDone) begin
            resultLowReg  <= trial[32] ? {quot_q[30:0], 1'b0}
                                       : {quot_q[30:0], 1'b1};
            resultHighReg <= trial[32] ? {rem_q[30:0], quot_q[31]}
                                       : trial[31:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status, shadow sets, load-linked flag
    logic irqOk;
    logic eretOk;
    assign irqOk  = isIrqInstr && fire && cop0Usable && ARCH_REV >= 2;
    assign eretOk = isEret && fire && cop0Usable;

    // One-cycle read-modify-write: nothing can slip between
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            statusWord <= STATUS_RST;
        end else if (irqOk) begin
            statusWord[ST_IE] <= issue.instr[SEL_BIT];
        end else if (eretOk) begin
            if (statusWord[ST_ERL]) begin
                statusWord[ST_ERL] <= 1'b0;
            end else begin
                statusWord[ST_EXL] <= 1'b0;
            end
        end else if (statusWe) begin
            statusWord <= statusWdata;
        end
    end
    assign globalIrqEnable = statusWord[ST_IE];

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            shadowSetControl <= '{SHADOW_RST, SHADOW_RST, SHADOW_RST};
        end else if (eretOk && ARCH_REV >= 2
                     && shadowSetControl.highest != 4'h0
                     && !statusWord[ST_BEV] && !statusWord[ST_ERL]) begin
            shadowSetControl.current <= shadowSetControl.previous;
        end else if (shadowWe) begin
            shadowSetControl <= shadowWdata;
        end
    end

    // Clear wins: return must always break a pending reservation
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            loadLinkedFlag <= 1'b0;
        end else if (eretOk) begin
            loadLinkedFlag <= 1'b0;
        end else if (loadLinkedSet) begin
            loadLinkedFlag <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Extract: msbd and lsb fields
    logic [4:0]  msbd;
    logic [4:0]  lsbF;
    logic [31:0] shifted;
    logic [31:0] fieldMask;
    assign msbd      = issue.instr[MSBD_HI:MSBD_LO];
    assign lsbF      = issue.instr[LSB_HI:LSB_LO];
    assign shifted   = issue.rsVal >> lsbF;
    // Out-of-range fields just give the masked shift, no check
    assign fieldMask = 32'hFFFF_FFFF >> (5'd31 - msbd);

    ////////////////////////////////////////////////////////////////////////
    // Write-back, exceptions, redirect
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            writeBack <= '0;
        end else begin
            writeBack.we <= 1'b0;
            if (irqOk && rtF != 5'h00) begin
                writeBack <= '{1'b1, rtF, statusWord};
            end else if (isExtract && fire && ARCH_REV >= 2) begin
                writeBack <= '{rtF != 5'h00, rtF,
                               shifted & fieldMask};
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            excValid <= 1'b0;
            excCause <= DHIE_EXC_NONE;
        end else begin
            excValid <= 1'b0;
            excCause <= DHIE_EXC_NONE;
            if (fire && (isIrqInstr || isExtract) && ARCH_REV < 2) begin
                excValid <= 1'b1;
                excCause <= DHIE_EXC_RI;
            end else if (fire && (isIrqInstr || isEret) && !cop0Usable) begin
                excValid <= 1'b1;
                excCause <= DHIE_EXC_CPU;
            end
        end
    end

    logic [31:0] retTarget;
    assign retTarget = statusWord[ST_ERL] ? errorReturnPc
                                          : exceptionReturnPc;

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            redirectValid     <= 1'b0;
            redirectPc        <= 32'h0000_0000;
            isaSelect         <= 1'b0;
            squashNext        <= 1'b0;
            clearExecHazards  <= 1'b0;
            clearInstrHazards <= 1'b0;
        end else begin
            redirectValid     <= eretOk;
            squashNext        <= eretOk;
            // Barrier clears execution hazards only
            clearExecHazards  <= eretOk || (isBarrier && fire);
            clearInstrHazards <= eretOk;
            if (eretOk) begin
                if (compressedIsa) begin
                    redirectPc <= {retTarget[31:1], 1'b0};
                    isaSelect  <= retTarget[0];
                end else begin
                    redirectPc <= retTarget;
                end
            end
        end
    end

endmodule
`default_nettype wire

// ---- dhie_exec_sva.sv ----
// Port checker for the execution unit
`default_nettype none
module dhie_exec_sva
    import dhie_pkg::*;
#(
    parameter int ARCH_REV  = ARCH_REV_DEF,
    parameter int DIV_STEPS = DIV_CYCLES
) (
    input wire logic        clk,
    input wire logic        reset,
    input wire dhie_issue_t issue,
    input wire logic        cop0Usable,
    input wire logic        compressedIsa,
    input wire logic        hazardPending,
    input wire logic [31:0] errorReturnPc,
    input wire logic        issueStall,
    input wire dhie_wb_t    writeBack,
    input wire logic        excValid,
    input wire dhie_exc_t   excCause,
    input wire logic        redirectValid,
    input wire logic [31:0] redirectPc,
    input wire logic        clearExecHazards,
    input wire logic        clearInstrHazards,
    input wire logic        squashNext,
    input wire logic [31:0] statusWord,
    input wire logic        globalIrqEnable,
    input wire logic        loadLinkedFlag,
    input wire logic        divBusy
);
    logic [31:0] ins;
    logic        take;
    logic        isMisc;
    logic        isEret;
    logic        isDiv;
    logic        isEhb;
    assign ins = issue.instr;
    assign take = issue.valid && !issueStall;
    assign isMisc = ins[31:26] == OP_SYSCOP && ins[25:21] == RS_MISC
        && ins[15:11] == RD_STATUS && ARCH_REV >= 2;
    assign isEret = ins[31:26] == OP_SYSCOP && ins[25:21] == RS_CO
        && ins[5:0] == FN_EXCEPTION_RETURN && cop0Usable;
    assign isDiv = ins[31:26] == OP_SPECIAL && ins[5:0] == FN_UDIV;
    assign isEhb = ins == 32'h0000_00C0;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    ////////////////////////////////////////////////////////////////////
    a_ei_old_status: assert property (
        take && isMisc && ins[SEL_BIT] && cop0Usable && ins[20:16] != 5'h00
        |=> writeBack.data == $past(statusWord) && globalIrqEnable)
        else $error("old status not returned");
    a_cpu_unusable: assert property (
        take && isMisc && !cop0Usable |=> excValid
        && excCause == DHIE_EXC_CPU && statusWord == $past(statusWord))
        else $error("missing unusable exception");
    a_div_no_exc: assert property (take && isDiv |=> !excValid)
        else $error("divide raised exception");
    a_barrier_stall: assert property (
        issue.valid && isEhb && hazardPending |-> issueStall)
        else $error("barrier issued over hazard");
    a_barrier_no_iclr: assert property (
        take && isEhb |=> clearExecHazards && !clearInstrHazards)
        else $error("barrier hazard clearing wrong");
    a_exception_return_error_pc: assert property (
        take && isEret && statusWord[ST_ERL] |=> redirectValid
        && !statusWord[ST_ERL] && redirectPc ==
        ($past(errorReturnPc) & ~{31'h0, $past(compressedIsa)}))
        else $error("error return wrong");
    a_exception_return_ll_squash: assert property (
        take && isEret |=> !loadLinkedFlag && squashNext && clearInstrHazards)
        else $error("return side effects missing");
    // Fixed span of the bit-serial divider, one step per bit
    a_div_busy_span: assert property (
        take && isDiv |=> divBusy ##32 !divBusy)
        else $error("divide busy span wrong");
endmodule
bind dhie_exec dhie_exec_sva #(.ARCH_REV(ARCH_REV), .DIV_STEPS(DIV_STEPS))
    u_dhie_exec_sva (.clk(clk), .reset(reset), .issue(issue),
    .cop0Usable(cop0Usable), .compressedIsa(compressedIsa),
    .hazardPending(hazardPending), .errorReturnPc(errorReturnPc),
    .issueStall(issueStall), .writeBack(writeBack), .excValid(excValid),
    .excCause(excCause), .redirectValid(redirectValid),
    .redirectPc(redirectPc), .clearExecHazards(clearExecHazards),
    .clearInstrHazards(clearInstrHazards), .squashNext(squashNext),
    .statusWord(statusWord), .globalIrqEnable(globalIrqEnable),
    .loadLinkedFlag(loadLinkedFlag), .divBusy(divBusy));
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the execution unit
`default_nettype none
module tb
    import dhie_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         clk, reset, cop0Usable, compressedIsa, hazardPending;
    logic         loadLinkedSet, shadowWe, statusWe;
    dhie_issue_t  issue;
    dhie_shadow_t shadowWdata, shadowSetControl;
    logic [31:0]  exceptionReturnPc, errorReturnPc, statusWdata, redirectPc;
    logic         issueStall, excValid, redirectValid, isaSelect, divBusy;
    logic         clearExecHazards, clearInstrHazards, squashNext;
    logic         globalIrqEnable, loadLinkedFlag;
    logic [31:0]  statusWord, resultHighReg, resultLowReg;
    dhie_wb_t     writeBack;
    dhie_exc_t    excCause;
    int           n_mismatch, compares, i;
    logic [63:0]  e;
    logic [31:0]  da [4] = '{32'h64, 32'hFFFF_FFFF, 32'h8000_0000, 32'h5};
    logic [31:0]  db [4] = '{32'h7, 32'h2, 32'hFFFF_FFFF, 32'h0};
    int           ep [4] = '{0, 31, 4, 8};
    int           es [4] = '{32, 1, 8, 16};
    dhie_exec u_dhie_exec (.clk(clk), .reset(reset), .issue(issue),
        .cop0Usable(cop0Usable), .compressedIsa(compressedIsa),
        .hazardPending(hazardPending), .exceptionReturnPc(exceptionReturnPc),
        .errorReturnPc(errorReturnPc), .issueStall(issueStall),
        .writeBack(writeBack), .excValid(excValid), .excCause(excCause),
        .redirectValid(redirectValid), .redirectPc(redirectPc),
        .isaSelect(isaSelect), .clearExecHazards(clearExecHazards),
        .clearInstrHazards(clearInstrHazards), .squashNext(squashNext),
        .statusWord(statusWord), .globalIrqEnable(globalIrqEnable),
        .shadowSetControl(shadowSetControl), .loadLinkedFlag(loadLinkedFlag),
        .loadLinkedSet(loadLinkedSet), .shadowWe(shadowWe),
        .shadowWdata(shadowWdata), .statusWe(statusWe),
        .statusWdata(statusWdata), .resultHighReg(resultHighReg),
        .resultLowReg(resultLowReg), .divBusy(divBusy));
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wrap_up;
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // Bounded wait for the take, then one cycle to see the pulses
    task automatic take_it;
        int k;
        for (k = 0; k < 200; k++) begin
            @(negedge clk);
            if (issueStall === 1'b0) break;
        end
        if (k == 200) begin
            n_mismatch++;
            wrap_up;
        end
        @(posedge clk) issue.valid <= 1'b0;
        @(negedge clk);
    endtask
    task automatic run(input logic [31:0] ins, a, b);
        @(posedge clk) issue <= '{1'b1, ins, a, b};
        take_it;
    endtask
    task automatic wr_sys(input logic [31:0] st, input dhie_shadow_t sh);
        @(posedge clk) {statusWe, shadowWe, statusWdata, shadowWdata}
            <= {2'b11, st, sh};
        @(posedge clk) {statusWe, shadowWe} <= 2'b00;
    endtask
    ////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        {cop0Usable, hazardPending, loadLinkedSet, shadowWe, statusWe} = '0;
        {issue, shadowWdata, statusWdata} = '0;
        compressedIsa = 1'b1;
        errorReturnPc = 32'h0000_1235;
        exceptionReturnPc = 32'h0000_2001;
        reset = 1'b1;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        run(32'h4162_6020, 0, 0);
        chk(excValid, 1);
        chk(excCause, DHIE_EXC_CPU);
        chk(statusWord, STATUS_RST);
        @(posedge clk) cop0Usable <= 1'b1;
        run(32'h4162_6020, 0, 0);
        chk({writeBack.we, writeBack.addr}, 6'h22);
        chk(writeBack.data, STATUS_RST);
        chk(globalIrqEnable, 1);
        run(32'h4163_6000, 0, 0);
        chk(writeBack.data, STATUS_RST | 32'h1);
        chk(globalIrqEnable, 0);
        @(posedge clk) {hazardPending, issue} <= {1'b1, 1'b1, 32'hC0, 64'h0};
        repeat (3) @(negedge clk) chk(issueStall, 1);
        @(posedge clk) hazardPending <= 1'b0;
        take_it;
        chk({clearExecHazards, clearInstrHazards}, 2'b10);
        @(posedge clk) loadLinkedSet <= 1'b1;
        @(posedge clk) loadLinkedSet <= 1'b0;
        run(32'h4200_0018, 0, 0);
        chk({redirectValid, isaSelect}, 2'b11);
        chk(redirectPc, 32'h0000_1234);
        chk(statusWord[ST_ERL], 0);
        chk(loadLinkedFlag, 0);
        chk({squashNext, clearInstrHazards}, 2'b11);
        // Shadow copy allowed only with the bootstrap bit clear
        for (i = 0; i < 2; i++) begin
            wr_sys({9'h0, i[0], 20'h0, 2'b10}, 12'h320);
            // Second pass without the compressed ISA: bit 0 kept
            compressedIsa <= (i == 0);
            run(32'h4200_0018, 0, 0);
            chk(redirectPc, i ? 32'h0000_2001 : 32'h0000_2000);
            chk(statusWord[ST_EXL], 0);
            chk(shadowSetControl.current, i ? 32'h0 : 32'h2);
        end
        for (i = 0; i < 4; i++) begin
            run(32'h0022_001B, da[i], db[i]);
            chk(excValid, 0);
            @(posedge clk) issue <= '{1'b1, 32'h0000_2012, 32'h0, 32'h0};
            @(negedge clk) chk(issueStall, 1);
            take_it;
            if (db[i] !== 32'h0) begin
                chk(resultLowReg, da[i] / db[i]);
                chk(resultHighReg, da[i] % db[i]);
            end
        end
        for (i = 0; i < 4; i++) begin
            run(32'h7C25_0000 | ((es[i] - 1) << 11) | (ep[i] << 6),
                32'hDEAD_BEEF, 0);
            e = (64'hDEAD_BEEF >> ep[i]) & ((64'h1 << es[i]) - 64'h1);
            chk(writeBack.data, e[31:0]);
            chk({writeBack.we, writeBack.addr}, 6'h25);
        end
        wrap_up;
    end
endmodule
`default_nettype wire
